// file: mix_asserts.sv
// port checks for mix_core
// assumes one clk domain, rstn synchronous active low
`timescale 1ns/1ps
module mix_asserts
  import mix_pkg::*;
(
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic [3:0]        phase,
  input wire logic [PC_W-1:0]   prog_addr,
  input wire logic              branch_taken,
  input wire logic [PC_W-1:0]   branch_target,
  input wire logic              ext_enable,
  input wire logic [BANK_W-1:0] bank_select_register,
  input wire logic [FILE_W-1:0] file_rdata,
  input wire logic [ADDR_W-1:0] file_addr,
  input wire logic              file_rd,
  input wire logic              file_wr,
  input wire logic [FILE_W-1:0] file_wdata,
  input wire mix_flags_t        flags,
  input wire mix_dec_t          decoded
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_rest_of_cycle;
    phase[1] ##1 phase[2] ##1 phase[3] ##1 phase[0];
  endsequence
  a_phase_onehot: assert property ($past(rstn) |-> $onehot(phase))
    else $error("phase not one-hot");
  a_phase_order: assert property (phase[0] |=> s_rest_of_cycle)
    else $error("phase order broken");
  a_fetch_edge: assert property ($changed(prog_addr) |-> phase[0])
    else $error("pc moved outside q4 edge");
  a_pc_step: assert property (phase[3] && !branch_taken |=>
    prog_addr == $past(prog_addr) + 16'h0001) else $error("pc did not step");
  a_branch_load: assert property (phase[3] && branch_taken && decoded.cls != CLS_NOP
    |=> prog_addr == $past(branch_target)) else $error("branch not taken");
  a_read_phase: assert property (file_rd |-> phase[1] && decoded.rot_op)
    else $error("read strobe out of place");
  a_write_phase: assert property (file_wr |-> phase[3] &&
    (decoded.set_op || decoded.rot_op && decoded.dest)) else $error("bad write");
  a_set_data: assert property (file_wr && decoded.set_op |-> file_wdata == ALL_ONES)
    else $error("set wrote wrong data");
  a_set_flags: assert property (decoded.set_op |=> $stable(flags))
    else $error("set changed flags");
  a_rot_data: assert property (file_wr && decoded.rot_op |->
    file_wdata == {$past(file_rdata[0], 2), $past(file_rdata[7:1], 2)})
    else $error("bad rotate");
  a_bank_sel: assert property (phase[2] && decoded.rot_op && decoded.acc |->
    file_addr == {bank_select_register, decoded.file}) else $error("bank select ignored");
  a_access_bank: assert property (phase[2] && decoded.rot_op && !decoded.acc
    && !ext_enable |-> file_addr == {(decoded.file < ACCESS_SPLIT) ? ACCESS_LO_BANK
    : ACCESS_HI_BANK, decoded.file}) else $error("access bank wrong");
endmodule : mix_asserts
bind mix_core mix_asserts chk_u (.clk, .rstn, .phase, .prog_addr, .branch_taken, .branch_target,
  .ext_enable, .bank_select_register, .file_rdata, .file_addr, .file_rd, .file_wr, .file_wdata,
  .flags, .decoded);

// file: mix_core.sv
// instruction format decoder and executor of an 8-bit core
// assumes program memory and file registers answer combinationally on clk
//
// Operation
// - The core provides 75 standard instructions plus an optional extended group of 8.
// - A single-word instruction is one 16-bit word of opcode and operand fields.
// - Exactly four instructions take two program words, all others take one.
// - A second word has ones in its top four bits and runs as a no-operation alone.
// - Destination bit 0 sends the result to the working register, 1 back to the file.
// - Bit operations act on the bit numbered by the bit field in the named file; the core only decodes them into bitn and writes nothing.
// - A single word takes one cycle, two when a test is true or the counter jumps; the core adds the second cycle only on branch_taken.
// - Every double-word instruction takes two instruction cycles.
// - Each instruction cycle is four oscillator periods.
// - Access bit 0 selects the access bank, 1 takes the bank from the bank select register.
// - With the extended group on, access bit 0 and file at most 95 use indexed offset.
// - Rotate right without carry moves bit 0 to bit 7 and updates negative and zero.
// - Omitted destination and access operands default to file write and banked access.
// - Set all ones writes FFh to the addressed register and leaves flags alone.
`timescale 1ns/1ps
module mix_core
  import mix_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ext_enable,
  input  wire logic [BANK_W-1:0] bank_select_register,
  input  wire logic [ADDR_W-1:0] index_base,
  input  wire logic              branch_taken,
  input  wire logic [PC_W-1:0]   branch_target,
  input  wire logic [WORD_W-1:0] prog_word,
  output logic      [PC_W-1:0]   prog_addr,
  input  wire logic [FILE_W-1:0] file_rdata,
  output logic      [ADDR_W-1:0] file_addr,
  output logic                   file_rd,
  output logic                   file_wr,
  output logic      [FILE_W-1:0] file_wdata,
  output logic      [FILE_W-1:0] working_register,
  output mix_flags_t             flags,
  output mix_dec_t               decoded,
  output logic      [WORD_W-1:0] second_word,
  output logic      [3:0]        phase
);

  logic [PC_W-1:0]   pc_reg;
  logic [WORD_W-1:0] ir_reg;
  logic [WORD_W-1:0] second_reg;
  mix_dec_t          dec_reg;
  logic              nop_reg;
  logic              second_pend_reg;
  logic              flush_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [FILE_W-1:0] result_reg;
  logic [FILE_W-1:0] operand_reg;
  logic [FILE_W-1:0] working_reg;
  mix_flags_t        flags_reg;
  logic              q1;
  logic              q2;
  logic              q3;
  logic              q4;
  logic              active;
  logic              wr_file;

  mix_phase u_phase (
    .clk   (clk),
    .rstn  (rstn),
    .phase (phase)
  );

  assign q1 = phase[0];
  assign q2 = phase[1];
  assign q3 = phase[2];
  assign q4 = phase[3];

  // classify one program word
  function automatic mix_dec_t decode(input logic [WORD_W-1:0] w, input logic ext);
    mix_dec_t r;
    logic [3:0] top;
    r        = '0;
    top      = w[OPC_HI -: 4];
    r.file   = w[FILE_HI:0];
    r.dest   = w[DEST_POS];
    r.acc    = w[ACC_POS];
    r.bitn   = w[BIT_LO +: BIT_W];
    r.rot_op = (w[OPC_HI -: 6] == OPC_ROT_RIGHT);
    r.set_op = (w[OPC_HI -: 7] == OPC_SET_ONES);
    if (top == SECOND_WORD_TAG) begin
      r.cls = CLS_NOP;
    end else if (top == OPC_DBL_MOVE || w[OPC_HI -: 7] == OPC_DBL_CALL ||
                 w[OPC_HI -: 10] == OPC_DBL_LOADPTR || w[OPC_HI -: 8] == OPC_DBL_JUMP) begin
      r.cls = CLS_DOUBLE;
    end else if (top == 4'h7 || top[3:2] == 2'b10) begin
      r.cls = CLS_BIT;
    end else if ((top != 4'h0 && top[3] == 1'b0) || w[11:9] != 3'h0) begin
      r.cls = CLS_BYTE;
    end else begin
      r.cls = CLS_CTRL;
    end
    if (w[OPC_HI -: 8] == 8'hE8) begin
      r.cls = ext ? CLS_CTRL : CLS_NOP;
    end
    return r;
  endfunction : decode

  // resolve the file operand to a data address
  function automatic logic [ADDR_W-1:0] resolve(input mix_dec_t d,
                                                input logic ext,
                                                input logic [BANK_W-1:0] bank,
                                                input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] r;
    r = {bank, d.file};
    if (!d.acc) begin
      if (ext && d.file <= INDEXED_MAX) begin
        r = base + {{(ADDR_W-FILE_W){1'b0}}, d.file};
      end else if (d.file < ACCESS_SPLIT) begin
        r = {ACCESS_LO_BANK, d.file};
      end else begin
        r = {ACCESS_HI_BANK, d.file};
      end
    end
    return r;
  endfunction : resolve

  assign active  = !nop_reg && (dec_reg.rot_op || dec_reg.set_op);
  assign wr_file = dec_reg.set_op || dec_reg.dest;

  // phase 1: decode, and mark cycles that run as no-operation
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dec_reg <= '0;
      nop_reg <= 1'b1;
    end else if (q1) begin
      dec_reg <= decode(ir_reg, ext_enable);
      nop_reg <= flush_reg || second_pend_reg;
    end
  end

  // phase 1: operand address, stable for the read in phase 2
  always_ff @(posedge clk) begin
    if (!rstn) begin
      addr_reg <= '0;
    end else if (q1) begin
      addr_reg <= resolve(decode(ir_reg, ext_enable), ext_enable, bank_select_register,
                          index_base);
    end
  end

  // phase 2: read the operand
  always_ff @(posedge clk) begin
    if (!rstn) begin
      operand_reg <= '0;
    end else if (file_rd) begin
      operand_reg <= file_rdata;
    end
  end

  // phase 3: process data
  always_ff @(posedge clk) begin
    if (!rstn) begin
      result_reg <= '0;
    end else if (q3 && active) begin
      if (dec_reg.set_op) begin
        result_reg <= ALL_ONES;
      end else begin
        result_reg <= {operand_reg[0], operand_reg[FILE_W-1:1]};
      end
    end
  end

  // phase 4: write destination
  always_ff @(posedge clk) begin
    if (!rstn) begin
      working_reg <= WORKREG_RESET;
    end else if (q4 && active && !wr_file) begin
      working_reg <= result_reg;
    end
  end

  // status flags, only from rotate
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags_reg <= '0;
    end else if (q4 && active && dec_reg.rot_op) begin
      flags_reg.neg  <= result_reg[FILE_W-1];
      flags_reg.zero <= (result_reg == '0);
    end
  end

  // phase 4: fetch next word, sequence double words and flushes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pc_reg          <= PC_RESET;
      ir_reg          <= IR_RESET;
      second_reg      <= '0;
      second_pend_reg <= 1'b0;
      flush_reg       <= 1'b0;
    end else if (q4) begin
      ir_reg          <= prog_word;
      second_pend_reg <= !nop_reg && dec_reg.cls == CLS_DOUBLE;
      flush_reg       <= !nop_reg && branch_taken;
      if (second_pend_reg) begin
        second_reg <= ir_reg;
      end
      if (!nop_reg && branch_taken) begin
        pc_reg <= branch_target;
      end else begin
        pc_reg <= pc_reg + PC_W'(1);
      end
    end
  end

  assign prog_addr        = pc_reg;
  assign file_addr        = addr_reg;
  assign file_rd          = q2 && active && dec_reg.rot_op;
  assign file_wr          = q4 && active && wr_file;
  assign file_wdata       = result_reg;
  assign working_register = working_reg;
  assign flags            = flags_reg;
  assign decoded          = dec_reg;
  assign second_word      = second_reg;

endmodule : mix_core

// file: mix_mem.sv
// program memory and file register model
// assumes reads answer at once, file writes land on clk
`timescale 1ns/1ps
module mix_mem
  import mix_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [PC_W-1:0]   prog_addr,
  output logic      [WORD_W-1:0] prog_word,
  input  wire logic [ADDR_W-1:0] file_addr,
  input  wire logic              file_rd,
  input  wire logic              file_wr,
  input  wire logic [FILE_W-1:0] file_wdata,
  output logic      [FILE_W-1:0] file_rdata
);
  logic [WORD_W-1:0] rom [64];
  logic [FILE_W-1:0] ram [4096];
  assign prog_word  = rom[prog_addr[5:0]];
  // data only valid while read strobe is up
  assign file_rdata = file_rd ? ram[file_addr] : ~ram[file_addr];
  always @(posedge clk) begin
    if (file_wr) begin
      ram[file_addr] <= file_wdata;
    end
  end
endmodule : mix_mem

// file: mix_phase.sv
// four-phase sequencer: one instruction cycle per four clock periods
// assumes clk is the core oscillator and rstn is synchronous
`timescale 1ns/1ps
module mix_phase
  import mix_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  output logic      [3:0] phase
);

  logic [PHASE_W-1:0] cnt_reg;

  // wraps after four periods
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + PHASE_W'(1);
    end
  end

  // one-hot phase enables, q1 first
  genvar i;
  generate
    for (i = 0; i < OSC_PER_ICYC; i++) begin : g_ph
      assign phase[i] = rstn && (cnt_reg == PHASE_W'(i));
    end
  endgenerate

endmodule : mix_phase

// file: mix_pkg.sv
// package for the instruction format decoder and executor
// assumes one 100 MHz core clock; the core oscillator period is one clk cycle
package mix_pkg;

  // instruction set sizes
  localparam int          STD_INSTR_COUNT = 75;
  localparam int          EXT_INSTR_COUNT = 8;

  // word and field widths
  localparam int          WORD_W          = 16;
  localparam int          PC_W            = 16;
  localparam int          FILE_W          = 8;
  localparam int          ADDR_W          = 12;
  localparam int          BANK_W          = 4;
  localparam int          BIT_W           = 3;

  // oscillator periods per instruction cycle
  localparam int          OSC_PER_ICYC    = 4;
  localparam int          PHASE_W         = 2;

  // field positions in a single word
  localparam int          OPC_HI          = 15;
  localparam int          DEST_POS        = 9;
  localparam int          ACC_POS         = 8;
  localparam int          BIT_LO          = 9;
  localparam int          FILE_HI         = 7;

  // encodings
  localparam logic [3:0]  SECOND_WORD_TAG = 4'hF;
  localparam logic [5:0]  OPC_ROT_RIGHT   = 6'h10;
  localparam logic [6:0]  OPC_SET_ONES    = 7'h34;
  localparam logic [3:0]  OPC_DBL_MOVE    = 4'hC;
  localparam logic [6:0]  OPC_DBL_CALL    = 7'h76;
  localparam logic [9:0]  OPC_DBL_LOADPTR = 10'h3B8;
  localparam logic [7:0]  OPC_DBL_JUMP    = 8'hEF;

  // addressing constants
  localparam logic [7:0]  INDEXED_MAX     = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;
  localparam logic [3:0]  ACCESS_LO_BANK  = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK  = 4'hF;
  localparam logic [7:0]  ALL_ONES        = 8'hFF;

  // reset values
  localparam logic [15:0] PC_RESET        = 16'h0000;
  localparam logic [15:0] IR_RESET        = 16'hFFFF;
  localparam logic [7:0]  WORKREG_RESET   = 8'h00;

  typedef enum logic [2:0] {
    CLS_NOP,
    CLS_BYTE,
    CLS_BIT,
    CLS_CTRL,
    CLS_DOUBLE
  } mix_class_t;

  typedef struct packed {
    mix_class_t        cls;
    logic              rot_op;
    logic              set_op;
    logic [FILE_W-1:0] file;
    logic              dest;
    logic              acc;
    logic [BIT_W-1:0]  bitn;
  } mix_dec_t;

  typedef struct packed {
    logic neg;
    logic zero;
  } mix_flags_t;

endpackage : mix_pkg

// file: tb_top.sv
// self-checking bench for mix_core
// assumes mix_mem as far side and mix_asserts bound to the core
`timescale 1ns/1ps
module tb_top;
  import mix_pkg::*;
  logic              clk, rstn, ext_enable, branch_taken, file_rd, file_wr;
  logic [BANK_W-1:0] bank_select_register;
  logic [ADDR_W-1:0] index_base, file_addr;
  logic [PC_W-1:0]   branch_target, prog_addr;
  logic [WORD_W-1:0] prog_word, second_word;
  logic [FILE_W-1:0] file_rdata, file_wdata, working_register;
  logic [3:0]        phase;
  mix_flags_t        flags;
  mix_dec_t          decoded;
  int                mismatches, compares;
  mix_core dut_u (.clk, .rstn, .ext_enable, .bank_select_register, .index_base, .branch_taken,
    .branch_target, .prog_word, .prog_addr, .file_rdata, .file_addr, .file_rd, .file_wr,
    .file_wdata, .working_register, .flags, .decoded, .second_word, .phase);
  mix_mem mem_u (.clk, .prog_addr, .prog_word, .file_addr, .file_rd, .file_wr, .file_wdata,
    .file_rdata);
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // jump out of the instruction at address 7
  always @(posedge clk) begin
    #1;
    branch_taken = phase[3] && prog_addr === 16'h0008;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic run_prog(input logic ext);
    int n;
    for (int i = 0; i < 64; i++) begin
      mem_u.rom[i] = 16'hFFFF;
    end
    for (int i = 0; i < 4096; i++) begin
      mem_u.ram[i] = 8'h00;
    end
    {mem_u.rom[0], mem_u.rom[1], mem_u.rom[2], mem_u.rom[3], mem_u.rom[4]} =
      {16'h4210, 16'h4120, 16'h6930, 16'h6880, 16'hF123};
    {mem_u.rom[5], mem_u.rom[6], mem_u.rom[7], mem_u.rom[8]} =
      {16'hC123, 16'hF456, 16'h4250, 16'h6951};
    {mem_u.rom[32], mem_u.rom[33], mem_u.rom[34], mem_u.rom[35]} =
      {16'h4252, 16'h6870, 16'h8B45, 16'hE812};
    {mem_u.ram[12'h010], mem_u.ram[12'h210]} = {8'hD7, 8'hD7};
    {mem_u.ram[12'h420], mem_u.ram[12'h050]} = {8'h01, 8'h03};
    @(posedge clk);
    #1 rstn = 1'h0;
    ext_enable = ext;
    repeat (10) @(posedge clk);
    #1 rstn = 1'h1;
    n = 0;
    while (decoded.cls !== CLS_BIT && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 200) begin
      mismatches++;
      $display("mismatch at %0t: no bit instruction decoded", $time);
    end
    chk8({5'h00, decoded.bitn}, 8'h05);
    chk8(decoded.file, 8'h45);
    repeat (4) @(posedge clk);
    #1;
    chk8({5'h00, decoded.cls}, {5'h00, ext ? CLS_CTRL : CLS_NOP});
    repeat (4) @(posedge clk);
    #1;
    chk8(mem_u.ram[12'h010], ext ? 8'hD7 : 8'hEB);
    chk8(mem_u.ram[12'h210], ext ? 8'hEB : 8'hD7);
    chk8(mem_u.ram[12'h050], ext ? 8'h03 : 8'h81);
    chk8(working_register, 8'h80);
    chk8(mem_u.ram[12'h420], 8'h01);
    chk8(mem_u.ram[12'h430], 8'hFF);
    chk8(mem_u.ram[12'hF80], 8'hFF);
    chk16(second_word, 16'hF456);
    chk8(mem_u.ram[12'h451], 8'h00);
    chk8(mem_u.ram[12'hF70], 8'hFF);
    chk8({6'h00, flags}, 8'h01);
  endtask : run_prog
  initial begin
    {mismatches, compares} = 0;
    {rstn, ext_enable} = 2'h0;
    bank_select_register = 4'h4;
    index_base = 12'h200;
    branch_target = 16'h0020;
    run_prog(1'h0);
    $display("test banked addressing done");
    run_prog(1'h1);
    $display("test indexed addressing done");
    end_of_test();
  end
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
endmodule : tb_top
